// [design/clock_delay_tap.sv]
// selectable delay stage for a sampled clock level
// assumes the input is already in the i_clock domain
`timescale 1ns/100ps
module clock_delay_tap #(
    parameter int STAGES = 1
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_enable,
    input  wire logic i_level,
    output logic      o_level
);

    logic [STAGES-1:0] chain;

    // the shift form only exists for two or more stages, so no empty part-select is elaborated
    generate
        if (STAGES < 1) begin : g_bad_stages
            $error("clock_delay_tap needs at least one stage");
        end else if (STAGES == 1) begin : g_one_stage
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    chain <= '0;
                end else begin
                    chain <= i_level;
                end
            end
        end else begin : g_shift
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    chain <= '0;
                end else begin
                    chain <= {chain[STAGES-2:0], i_level};
                end
            end
        end
    endgenerate

    // bypass keeps the same single output flop so both settings share one timing path
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_level <= 1'b0;
        end else begin
            o_level <= i_enable ? chain[STAGES-1] : i_level;
        end
    end

endmodule : clock_delay_tap

// [design/xmii_port_mac_config.sv]
// port interface and switch MAC configuration bank with AXI4-Lite slave
// assumes software drives a single-clock AXI4-Lite master; the receive clock pin is asynchronous
`timescale 1ns/100ps
`include "xmii_port_mac_config_regs.svh"
module xmii_port_mac_config #(
    parameter bit MULTI_TYPE_PORT = 1'b1,
    parameter int DELAY_STAGES    = `RGMII_DELAY_CYCLES
) (
    input  wire logic                               i_clock,
    input  wire logic                               i_rst,
    input  wire logic [15:0]                        i_awaddr,
    input  wire logic                               i_awvalid,
    output logic                                    o_awready,
    input  wire logic [31:0]                        i_wdata,
    input  wire logic [3:0]                         i_wstrb,
    input  wire logic                               i_wvalid,
    output logic                                    o_wready,
    output logic [1:0]                              o_bresp,
    output logic                                    o_bvalid,
    input  wire logic                               i_bready,
    input  wire logic [15:0]                        i_araddr,
    input  wire logic                               i_arvalid,
    output logic                                    o_arready,
    output logic [31:0]                             o_rdata,
    output logic [1:0]                              o_rresp,
    output logic                                    o_rvalid,
    input  wire logic                               i_rready,
    input  wire logic                               i_receive_clock_pin,
    output logic                                    o_receive_clock_pin_out,
    output logic                                    o_receive_clock_pin_oe,
    input  wire logic                               i_tx_clock_level,
    output logic                                    o_rx_clock_level,
    output logic                                    o_tx_clock_level,
    output xmii_port_mac_config_pkg::port_cfg_t     o_cfg
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset view equals the register reset values, so bad frames are never let through at start
    localparam xmii_port_mac_config_pkg::port_cfg_t CFG_AT_RESET = '{
        iface:           xmii_port_mac_config_pkg::IFACE_RGMII,
        speed:           xmii_port_mac_config_pkg::SPEED_1000,
        tx_delay_en:     1'b1,
        full_duplex:     1'b1,
        pause_mode:      1'b1,
        drop_bad_frames: 1'b1,
        default:         1'b0
    };

    generate
        if (DELAY_STAGES < `RGMII_DELAY_CYCLES) begin : g_bad_delay
            $error("delay stages too few for the minimum clock delay");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    logic        aw_held;
    logic [15:0] aw_addr;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        aw_take;
    logic        w_take;
    logic        do_write;
    logic        next_aw_held;
    logic        next_w_held;
    logic        next_bvalid;

    assign aw_take      = o_awready & i_awvalid;
    assign w_take       = o_wready & i_wvalid;
    assign do_write     = aw_held & w_held & ~o_bvalid;
    assign next_aw_held = (aw_held | aw_take) & ~do_write;
    assign next_w_held  = (w_held | w_take) & ~do_write;
    assign next_bvalid  = do_write | (o_bvalid & ~i_bready);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 16'h0000;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            if (aw_take) begin
                aw_addr <= i_awaddr;
            end
            if (w_take) begin
                w_byte  <= i_wdata[7:0];
                w_lane0 <= i_wstrb[0];
            end
        end
    end

    // ready stays low while a write waits or its response is pending
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end else begin
            o_awready <= ~next_aw_held & ~next_bvalid;
            o_wready  <= ~next_w_held & ~next_bvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // address decode

    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_mac0;
    logic wr_mac1;
    logic wr_hit;

    always_comb begin
        wr_ctrl0 = 1'b0;
        wr_ctrl1 = 1'b0;
        wr_mac0  = 1'b0;
        wr_mac1  = 1'b0;
        wr_hit   = 1'b1;
        if (aw_addr == `XMII_CTRL0_ADDR) begin
            wr_ctrl0 = 1'b1;
        end else if (aw_addr == `XMII_CTRL1_ADDR) begin
            wr_ctrl1 = 1'b1;
        end else if (aw_addr == `MAC_CTRL0_ADDR) begin
            wr_mac0 = 1'b1;
        end else if (aw_addr == `MAC_CTRL1_ADDR) begin
            wr_mac1 = 1'b1;
        end else if (aw_addr != `CFG_STATUS_ADDR) begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else begin
            o_bvalid <= next_bvalid;
            if (do_write) begin
                o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // registers; only byte lane 0 carries data, other lanes are ignored

    logic [7:0] xmii_port_control_zero;
    logic [7:0] xmii_port_control_one;
    logic [7:0] port_mac_control_zero;
    logic [7:0] port_mac_control_one;
    logic       wr_ok;

    assign wr_ok = do_write & w_lane0;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            xmii_port_control_zero <= `XMII_CTRL0_RESET;
        end else if (wr_ok && wr_ctrl0) begin
            xmii_port_control_zero <= (xmii_port_control_zero & ~`XMII_CTRL0_WMASK)
                                    | (w_byte & `XMII_CTRL0_WMASK);
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            xmii_port_control_one <= `XMII_CTRL1_RESET;
        end else if (wr_ok && wr_ctrl1) begin
            xmii_port_control_one <= (xmii_port_control_one & ~`XMII_CTRL1_WMASK)
                                   | (w_byte & `XMII_CTRL1_WMASK);
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            port_mac_control_zero <= `MAC_CTRL0_RESET;
        end else if (wr_ok && wr_mac0) begin
            port_mac_control_zero <= (port_mac_control_zero & ~`MAC_CTRL0_WMASK)
                                   | (w_byte & `MAC_CTRL0_WMASK);
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            port_mac_control_one <= `MAC_CTRL1_RESET;
        end else if (wr_ok && wr_mac1) begin
            port_mac_control_one <= (port_mac_control_one & ~`MAC_CTRL1_WMASK)
                                  | (w_byte & `MAC_CTRL1_WMASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // effective configuration

    xmii_port_mac_config_pkg::port_cfg_t next_cfg;
    logic [1:0]                          type_code;
    logic                                low_speed;
    logic                                role_bit;

    always_comb begin
        // fixed port keeps gigabit RGMII MAC whatever software writes
        type_code = MULTI_TYPE_PORT ? xmii_port_control_one[`CTRL1_TYPE_LSB +: 2] : 2'h0;
        low_speed = MULTI_TYPE_PORT & xmii_port_control_one[`CTRL1_LOWSPEED_BIT];
        role_bit  = MULTI_TYPE_PORT & xmii_port_control_one[`CTRL1_ROLE_BIT];
        next_cfg  = '0;
        if (type_code == 2'h0) begin
            next_cfg.iface = xmii_port_mac_config_pkg::IFACE_RGMII;
        end else if (type_code == 2'h1) begin
            next_cfg.iface = xmii_port_mac_config_pkg::IFACE_RMII;
        end else begin
            next_cfg.iface = xmii_port_mac_config_pkg::IFACE_MII;
        end
        if (type_code == 2'h0 && !low_speed) begin
            next_cfg.speed = xmii_port_mac_config_pkg::SPEED_1000;
        end else if (xmii_port_control_zero[`CTRL0_SPEED100_BIT]) begin
            next_cfg.speed = xmii_port_mac_config_pkg::SPEED_100;
        end else begin
            next_cfg.speed = xmii_port_mac_config_pkg::SPEED_10;
        end
        next_cfg.phy_role           = role_bit & (type_code != 2'h0);
        next_cfg.rx_delay_en        = xmii_port_control_one[`CTRL1_RX_DELAY_BIT];
        next_cfg.tx_delay_en        = xmii_port_control_one[`CTRL1_TX_DELAY_BIT];
        next_cfg.full_duplex        = xmii_port_control_zero[`CTRL0_DUPLEX_BIT];
        next_cfg.pause_mode         = xmii_port_control_zero[`CTRL0_DUPLEX_BIT];
        next_cfg.storm_protect      = port_mac_control_zero[`MAC0_STORM_BIT];
        next_cfg.back_pressure      = port_mac_control_one[`MAC1_BACKPR_BIT]
                                    & ~xmii_port_control_zero[`CTRL0_DUPLEX_BIT];
        // flow control frame filtering is not steered from here at all
        next_cfg.drop_bad_frames    = ~port_mac_control_one[`MAC1_PASS_ALL_BIT];
        next_cfg.bad_to_mirror_only = port_mac_control_one[`MAC1_PASS_ALL_BIT];
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_cfg <= CFG_AT_RESET;
        end else begin
            o_cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // receive clock pin: input in MAC or RMII-receive role, generated otherwise

    logic [5:0] half_limit;
    logic [5:0] half_count;

    always_comb begin
        if (o_cfg.iface == xmii_port_mac_config_pkg::IFACE_RMII) begin
            half_limit = 6'(`RMII_HALF_CYCLES);
        end else if (o_cfg.speed == xmii_port_mac_config_pkg::SPEED_100) begin
            half_limit = 6'(`MII_100_HALF_CYCLES);
        end else begin
            half_limit = 6'(`MII_10_HALF_CYCLES);
        end
    end

    // counter restarts when the pin is released so a new role starts with a clean phase
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            half_count              <= 6'h00;
            o_receive_clock_pin_out <= 1'b0;
        end else if (!o_cfg.phy_role) begin
            half_count              <= 6'h00;
            o_receive_clock_pin_out <= 1'b0;
        end else if (half_count >= half_limit - 6'h01) begin
            half_count              <= 6'h00;
            o_receive_clock_pin_out <= ~o_receive_clock_pin_out;
        end else begin
            half_count <= half_count + 6'h01;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_receive_clock_pin_oe <= 1'b0;
        end else begin
            o_receive_clock_pin_oe <= o_cfg.phy_role;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // clock delay paths

    logic rx_pin_meta;
    logic rx_pin_sync;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rx_pin_meta <= 1'b0;
            rx_pin_sync <= 1'b0;
        end else begin
            rx_pin_meta <= i_receive_clock_pin;
            rx_pin_sync <= rx_pin_meta;
        end
    end

    clock_delay_tap #(
        .STAGES (DELAY_STAGES)
    ) u_rx_delay (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_enable (o_cfg.rx_delay_en),
        .i_level  (rx_pin_sync),
        .o_level  (o_rx_clock_level)
    );

    clock_delay_tap #(
        .STAGES (DELAY_STAGES)
    ) u_tx_delay (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_enable (o_cfg.tx_delay_en),
        .i_level  (i_tx_clock_level),
        .o_level  (o_tx_clock_level)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    logic       ar_take;
    logic       next_rvalid;
    logic [7:0] rd_byte;
    logic       rd_hit;

    assign ar_take     = o_arready & i_arvalid;
    assign next_rvalid = ar_take | (o_rvalid & ~i_rready);

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (i_araddr == `XMII_CTRL0_ADDR) begin
            rd_byte = xmii_port_control_zero;
        end else if (i_araddr == `XMII_CTRL1_ADDR) begin
            rd_byte = xmii_port_control_one;
        end else if (i_araddr == `MAC_CTRL0_ADDR) begin
            rd_byte = port_mac_control_zero;
        end else if (i_araddr == `MAC_CTRL1_ADDR) begin
            rd_byte = port_mac_control_one;
        end else if (i_araddr == `CFG_STATUS_ADDR) begin
            rd_byte = {2'h0, o_receive_clock_pin_oe, o_cfg.phy_role, o_cfg.speed, o_cfg.iface};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end else begin
            o_arready <= ~next_rvalid;
            o_rvalid  <= next_rvalid;
            if (ar_take) begin
                o_rdata <= {24'h00_0000, rd_byte};
                o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    gigabit_select_a : assert property (
        (next_cfg.iface == xmii_port_mac_config_pkg::IFACE_RGMII && !low_speed)
        |=> o_cfg.speed == xmii_port_mac_config_pkg::SPEED_1000)
        else $error("gigabit not selected with speed select clear");
    low_speed_pick_a : assert property (
        (low_speed || type_code != 2'h0) ##1 1'b1
        |-> o_cfg.speed == ($past(xmii_port_control_zero[`CTRL0_SPEED100_BIT])
            ? xmii_port_mac_config_pkg::SPEED_100 : xmii_port_mac_config_pkg::SPEED_10))
        else $error("10/100 choice does not follow companion bit");
    rx_delay_path_a : assert property (
        (o_cfg.rx_delay_en && !$past(o_cfg.rx_delay_en)) ##1 o_cfg.rx_delay_en [*3]
        |-> o_rx_clock_level == $past(rx_pin_sync, DELAY_STAGES + 1))
        else $error("receive clock delay path wrong");
    tx_delay_hold_a : assert property (
        !(wr_ok && wr_ctrl1) |=> $stable(xmii_port_control_one[`CTRL1_TX_DELAY_BIT]))
        else $error("transmit delay bit changed without a write");
    pin_drive_role_a : assert property (
        1'b1 |=> o_receive_clock_pin_oe == $past(o_cfg.phy_role))
        else $error("clock pin not driven in phy role");
    rmii_refclk_a : assert property (
        (o_cfg.phy_role && o_cfg.iface == xmii_port_mac_config_pkg::IFACE_RMII
         && $changed(o_receive_clock_pin_out)) ##1 $stable(o_cfg) [*2]
        |-> $changed(o_receive_clock_pin_out))
        else $error("generated reference clock not at half period two");
    type_map_a : assert property (
        (type_code[1]) |=> o_cfg.iface == xmii_port_mac_config_pkg::IFACE_MII)
        else $error("type codes 10 and 11 must select MII");
    fixed_port_a : assert property (
        !MULTI_TYPE_PORT |-> (!o_cfg.phy_role && o_cfg.iface == 2'h0))
        else $error("fixed port honoured type or role");
    back_pressure_a : assert property (
        o_cfg.full_duplex |-> !o_cfg.back_pressure)
        else $error("back pressure active in full duplex");
    bad_frame_a : assert property (
        o_cfg.drop_bad_frames != o_cfg.bad_to_mirror_only)
        else $error("bad frame handling inconsistent");
    write_answer_a : assert property (
        do_write |=> o_bvalid ##0 (o_bresp == (($past(wr_hit)) ? RESP_OKAY : RESP_SLVERR)))
        else $error("write response not one cycle after write");
    read_answer_a : assert property (
        ar_take |=> o_rvalid)
        else $error("read data not one cycle after address");

    rmii_gen_c    : cover property (o_receive_clock_pin_oe
                                    && o_cfg.iface == xmii_port_mac_config_pkg::IFACE_RMII);
    mii_phy_c     : cover property (o_receive_clock_pin_oe
                                    && o_cfg.iface == xmii_port_mac_config_pkg::IFACE_MII);
    slverr_c      : cover property (o_bvalid && o_bresp == RESP_SLVERR);
    read_status_c : cover property (ar_take && i_araddr == `CFG_STATUS_ADDR);

endmodule : xmii_port_mac_config

// [design/xmii_port_mac_config_pkg.sv]
// types shared by the port configuration bank
// assumes the register map header is included by the design files
package xmii_port_mac_config_pkg;

    typedef enum logic [1:0] {
        IFACE_RGMII = 2'h0,
        IFACE_RMII  = 2'h1,
        IFACE_MII   = 2'h2
    } iface_t;

    typedef enum logic [1:0] {
        SPEED_10   = 2'h0,
        SPEED_100  = 2'h1,
        SPEED_1000 = 2'h2
    } speed_t;

    typedef struct packed {
        iface_t iface;
        speed_t speed;
        logic   phy_role;
        logic   rx_delay_en;
        logic   tx_delay_en;
        logic   full_duplex;
        logic   pause_mode;
        logic   storm_protect;
        logic   back_pressure;
        logic   drop_bad_frames;
        logic   bad_to_mirror_only;
    } port_cfg_t;

endpackage : xmii_port_mac_config_pkg

// [design/xmii_port_mac_config_regs.svh]
// register map, field positions, reset values and timing counts of the port configuration bank
// assumes a 200 MHz system clock and a 32-bit register bus with one register per aligned word
//
// Overview of operation
// - speed select clear runs RGMII at gigabit
// - speed select set: companion bit picks 10/100
// - companion bit: one 100, zero 10, gigabit ignores
// - rx delay bit adds at least 1.5 ns
// - tx delay bit, set at reset, adds delay
// - MII role bit: MAC takes clocks, PHY drives
// - RMII role bit: accept or generate 50 MHz
// - type 00 RGMII, 01 RMII, 1x MII
// - speed, role and type only on multi-type port
// - storm bit enables broadcast storm protection, resets zero
// - back pressure bit acts only in half duplex
// - full duplex uses pause flow control independently; here pause_mode is taken from the duplex bit itself
// - bad frames dropped by default
// - pass-all forwards bad frames to mirroring only
// - pass-all leaves flow control frame filtering alone
`ifndef XMII_PORT_MAC_CONFIG_REGS_SVH
`define XMII_PORT_MAC_CONFIG_REGS_SVH

`define XMII_CTRL0_INDEX     16'h0300
`define XMII_CTRL1_INDEX     16'h0301
`define MAC_CTRL0_INDEX      16'h0400
`define MAC_CTRL1_INDEX      16'h0401
`define CFG_STATUS_INDEX     16'h03FF
`define XMII_CTRL0_ADDR      (`XMII_CTRL0_INDEX << 2)
`define XMII_CTRL1_ADDR      (`XMII_CTRL1_INDEX << 2)
`define MAC_CTRL0_ADDR       (`MAC_CTRL0_INDEX << 2)
`define MAC_CTRL1_ADDR       (`MAC_CTRL1_INDEX << 2)
`define CFG_STATUS_ADDR      (`CFG_STATUS_INDEX << 2)

`define XMII_CTRL0_RESET     8'h50
`define XMII_CTRL1_RESET     8'h08
`define MAC_CTRL0_RESET      8'h00
`define MAC_CTRL1_RESET      8'h00
`define XMII_CTRL0_WMASK     8'h7F
`define XMII_CTRL1_WMASK     8'hFF
`define MAC_CTRL0_WMASK      8'h0B
`define MAC_CTRL1_WMASK      8'hBF

`define CTRL0_DUPLEX_BIT     6
`define CTRL0_SPEED100_BIT   4
`define CTRL1_LOWSPEED_BIT   6
`define CTRL1_RX_DELAY_BIT   4
`define CTRL1_TX_DELAY_BIT   3
`define CTRL1_ROLE_BIT       2
`define CTRL1_TYPE_LSB       0
`define MAC0_STORM_BIT       1
`define MAC1_BACKPR_BIT      3
`define MAC1_PASS_ALL_BIT    0

`define CLOCK_PERIOD_PS      5000
`define CLOCK_KHZ            200000
`define RGMII_DELAY_PS       1500
`define RGMII_DELAY_CYCLES   ((`RGMII_DELAY_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define RMII_REFCLK_KHZ      50000
`define MII_100_CLK_KHZ      25000
`define MII_10_CLK_KHZ       2500
`define RMII_HALF_CYCLES     (`CLOCK_KHZ / (2 * `RMII_REFCLK_KHZ))
`define MII_100_HALF_CYCLES  (`CLOCK_KHZ / (2 * `MII_100_CLK_KHZ))
`define MII_10_HALF_CYCLES   (`CLOCK_KHZ / (2 * `MII_10_CLK_KHZ))

`endif

// [testbench/xmii_far_end.sv]
// model of the external PHY or MAC facing the port's clock pins
// assumes the bench clock; its own clock runs free, as a PHY receive clock does
`timescale 1ns/100ps
module xmii_far_end (
    input  wire logic i_clock,
    input  wire logic i_pin_oe,
    input  wire logic i_pin_out,
    output logic      o_pin,
    output logic      o_tx_level
);
    logic ext_clock = 1'b0;
    always @(posedge i_clock) begin
        ext_clock <= ~ext_clock;
    end
    // the far side drives the shared pin only while the block leaves it
    assign o_pin      = i_pin_oe ? i_pin_out : ext_clock;
    assign o_tx_level = ext_clock;
endmodule : xmii_far_end

// [testbench/xmii_port_mac_config_tb.sv]
// self-checking bench: AXI4-Lite register tasks and port configuration checks
// assumes the register header and package are compiled before this file
`timescale 1ns/100ps
`include "xmii_port_mac_config_regs.svh"
module xmii_port_mac_config_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, pin, pin_out, pin_oe, tx_level;
    logic        rx_out, tx_out;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          t;
    xmii_port_mac_config_pkg::port_cfg_t cfg;
    always #2.5 clock = ~clock;
    xmii_port_mac_config dut_u (.i_clock(clock), .i_rst(rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_receive_clock_pin(pin), .o_receive_clock_pin_out(pin_out),
        .o_receive_clock_pin_oe(pin_oe), .i_tx_clock_level(tx_level),
        .o_rx_clock_level(rx_out), .o_tx_clock_level(tx_out), .o_cfg(cfg));
    xmii_far_end far_u (.i_clock(clock), .i_pin_oe(pin_oe), .i_pin_out(pin_out),
        .o_pin(pin), .o_tx_level(tx_level));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // write task returns one edge after the response, so o_cfg already shows it
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            mismatches++;
            give_verdict;
        end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            mismatches++;
            give_verdict;
        end
        chk(rdata, {24'h000000, d});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge clock);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd(`XMII_CTRL0_ADDR, 8'h50, 2'h0);
        rd(`XMII_CTRL1_ADDR, 8'h08, 2'h0);
        rd(`MAC_CTRL0_ADDR, 8'h00, 2'h0);
        rd(`MAC_CTRL1_ADDR, 8'h00, 2'h0);
        chk(cfg.speed, xmii_port_mac_config_pkg::SPEED_1000);
        chk(cfg.drop_bad_frames, 1'b1);
        chk({tx_out, rx_out}, {tx_level, !pin});
        $display("test reset_values done");
        for (t = 0; t < 8; t++) begin
            wr(`XMII_CTRL1_ADDR, t[7:0], 2'h0);
            chk(cfg.iface, t[1:0] == 2'h0 ? 2'h0 : (t[1:0] == 2'h1 ? 2'h1 : 2'h2));
            @(posedge clock);
            chk(pin_oe, t[2] && t[1:0] != 2'h0);
        end
        $display("test iface_role done");
        wr(`XMII_CTRL1_ADDR, 8'h40, 2'h0);
        chk(cfg.speed, xmii_port_mac_config_pkg::SPEED_100);
        wr(`XMII_CTRL0_ADDR, 8'h40, 2'h0);
        chk(cfg.speed, xmii_port_mac_config_pkg::SPEED_10);
        wr(`XMII_CTRL1_ADDR, 8'h10, 2'h0);
        chk(cfg.speed, xmii_port_mac_config_pkg::SPEED_1000);
        chk({cfg.rx_delay_en, cfg.tx_delay_en}, 2'h2);
        @(posedge clock);
        chk({tx_out, rx_out}, {!tx_level, pin});
        $display("test speed_delay done");
        wr(`MAC_CTRL0_ADDR, 8'hFF, 2'h0);
        rd(`MAC_CTRL0_ADDR, 8'h0B, 2'h0);
        chk(cfg.storm_protect, 1'b1);
        wr(`MAC_CTRL1_ADDR, 8'hFF, 2'h0);
        rd(`MAC_CTRL1_ADDR, 8'hBF, 2'h0);
        chk({cfg.back_pressure, cfg.pause_mode, cfg.bad_to_mirror_only}, 3'h3);
        wr(`XMII_CTRL0_ADDR, 8'h00, 2'h0);
        chk({cfg.back_pressure, cfg.pause_mode}, 2'h2);
        wr(`MAC_CTRL0_ADDR, 8'h00, 2'h0);
        chk(cfg.storm_protect, 1'b0);
        wr(16'h0008, 8'h55, 2'h2);
        rd(16'h0008, 8'h00, 2'h2);
        wr(`CFG_STATUS_ADDR, 8'hFF, 2'h0);
        rd(`CFG_STATUS_ADDR, 8'h08, 2'h0);
        $display("test mac_unmapped done");
        give_verdict;
    end
endmodule : xmii_port_mac_config_tb
